/* hdl/pfw_pkg.sv */
package pfw_pkg;
  // wait-state counter width and the largest count the sequencer serves
  localparam int PFW_WS_W = 5;
  localparam logic [4:0] PFW_WS_MAX = 5'h13;
  // reset values of the four timing counts
  localparam logic [4:0] PFW_SETUP_DEF = 5'h02;
  localparam logic [4:0] PFW_PULSE_DEF = 5'h0b;
  localparam logic [4:0] PFW_HOLD_DEF = 5'h02;
  localparam logic [4:0] PFW_ACC_DEF = 5'h13;
  // select indices; index one is the boot flash
  localparam int PFW_NUM_SEL = 3;
  localparam logic [1:0] PFW_SEL_FIRST = 2'h0;
  localparam logic [1:0] PFW_SEL_BOOT = 2'h1;
  localparam logic [1:0] PFW_SEL_THIRD = 2'h2;
  // per-device capacity: 128 Mbit of 16-bit words is 2^23 words
  localparam int PFW_ADDR_W = 23;
  localparam int PFW_DATA_W = 16;

  typedef enum logic [2:0] {
    PFW_IDLE,
    PFW_SETUP,
    PFW_PULSE,
    PFW_HOLD,
    PFW_ACCESS,
    PFW_DONE
  } pfw_state_t;
endpackage : pfw_pkg

/* hdl/pfw_sequencer.sv */
`timescale 1ns/1ps
//
// Contract
// - three active-low selects, 128 Mbit each
// - second select reserved for boot flash
// - each count programmable zero to 19
// - select-to-write-strobe lasts setup count
// - write strobe low lasts pulse count
// - select held hold count after strobe
// - read samples data after access count; pin value used is from two cycles before access phase ends
// - access count covers slowest access time
module pfw_sequencer
  import pfw_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_sel,
  input wire logic [PFW_ADDR_W-1:0] req_addr,
  input wire logic [PFW_DATA_W-1:0] req_wdata,
  input wire logic [PFW_WS_W-1:0] setup_count,
  input wire logic [PFW_WS_W-1:0] write_pulse_count,
  input wire logic [PFW_WS_W-1:0] select_hold_count,
  input wire logic [PFW_WS_W-1:0] read_access_count,
  input wire logic [PFW_DATA_W-1:0] flash_data_in,
  output logic req_ready,
  output logic rsp_valid,
  output logic [PFW_DATA_W-1:0] rsp_rdata,
  output logic flash_select_first_n,
  output logic boot_flash_select_n,
  output logic flash_select_third_n,
  output logic flash_write_strobe_n,
  output logic flash_read_strobe_n,
  output logic [PFW_ADDR_W-1:0] flash_addr,
  output logic [PFW_DATA_W-1:0] flash_data_out,
  output logic flash_data_oe
);
  pfw_state_t state_r;
  logic [PFW_WS_W-1:0] setup_r, pulse_r, hold_r, acc_r;
  logic [PFW_DATA_W-1:0] din_meta_r, din_sync_r;
  logic cnt_load;
  logic [PFW_WS_W-1:0] cnt_val;
  logic [PFW_WS_W-1:0] cnt;
  logic cnt_zero;
  logic start;
  logic all_sel_n;
  logic [PFW_WS_W:0] sel_lo_cnt_r;

  // counts saturate at the ceiling so a bad setting cannot stretch a phase
  function automatic logic [PFW_WS_W-1:0] pfw_clip(input logic [PFW_WS_W-1:0] v);
    return (v > PFW_WS_MAX) ? PFW_WS_MAX : v;
  endfunction : pfw_clip

  // clipped count capture
  // counts sampled at request time; mid-cycle changes do not disturb a transfer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_r <= PFW_SETUP_DEF;
      pulse_r <= PFW_PULSE_DEF;
      hold_r <= PFW_HOLD_DEF;
      acc_r <= PFW_ACC_DEF;
    end else if (start) begin
      setup_r <= pfw_clip(setup_count);
      pulse_r <= pfw_clip(write_pulse_count);
      hold_r <= pfw_clip(select_hold_count);
      acc_r <= pfw_clip(read_access_count);
    end
  end

  // refused in the ready cycle: a request still held there is the one just served
  assign start = (state_r == PFW_IDLE) && req_valid && !req_ready;

  pfw_ws_counter #(.WIDTH(PFW_WS_W)) u_cnt (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(cnt_load),
    .load_val(cnt_val),
    .count(cnt),
    .zero(cnt_zero)
  );

  // counter reload at each phase entry
  always_comb begin
    cnt_load = 1'b0;
    cnt_val = '0;
    if (start) begin
      cnt_load = 1'b1;
      cnt_val = req_write ? pfw_clip(setup_count) : pfw_clip(read_access_count);
    end else if (state_r == PFW_SETUP && cnt_zero) begin
      cnt_load = 1'b1;
      cnt_val = pulse_r;
    end else if (state_r == PFW_PULSE && cnt_zero) begin
      cnt_load = 1'b1;
      cnt_val = hold_r;
    end
  end

  // phase sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PFW_IDLE;
    end else begin
      case (state_r)
        PFW_IDLE: begin
          if (start) begin
            state_r <= req_write ? PFW_SETUP : PFW_ACCESS;
          end
        end
        PFW_SETUP: if (cnt_zero) state_r <= PFW_PULSE;
        PFW_PULSE: if (cnt_zero) state_r <= PFW_HOLD;
        PFW_HOLD: if (cnt_zero) state_r <= PFW_DONE;
        PFW_ACCESS: if (cnt_zero) state_r <= PFW_DONE;
        PFW_DONE: state_r <= PFW_IDLE;
        default: state_r <= PFW_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_select_first_n <= 1'b1;
      boot_flash_select_n <= 1'b1;
      flash_select_third_n <= 1'b1;
    end else if (start) begin
      flash_select_first_n <= (req_sel != PFW_SEL_FIRST);
      boot_flash_select_n <= (req_sel != PFW_SEL_BOOT);
      flash_select_third_n <= (req_sel != PFW_SEL_THIRD);
    end else if ((state_r == PFW_HOLD || state_r == PFW_ACCESS) && cnt_zero) begin
      flash_select_first_n <= 1'b1;
      boot_flash_select_n <= 1'b1;
      flash_select_third_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_write_strobe_n <= 1'b1;
    end else if (state_r == PFW_SETUP && cnt_zero) begin
      flash_write_strobe_n <= 1'b0;
    end else if (state_r == PFW_PULSE && cnt_zero) begin
      flash_write_strobe_n <= 1'b1;
    end
  end

  // read strobe low through the access phase on every read, even when req_sel matches no select
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_read_strobe_n <= 1'b1;
    end else if (start) begin
      flash_read_strobe_n <= req_write;
    end else if (state_r == PFW_ACCESS && cnt_zero) begin
      flash_read_strobe_n <= 1'b1;
    end
  end

  // address and write data held for the whole transfer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_addr <= '0;
      flash_data_out <= '0;
      flash_data_oe <= 1'b0;
    end else if (start) begin
      flash_addr <= req_addr;
      flash_data_out <= req_wdata;
      flash_data_oe <= req_write;
    end else if (state_r == PFW_HOLD && cnt_zero) begin
      flash_data_oe <= 1'b0;
    end
  end

  // flash data is asynchronous to core_clk: two stages before use
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      din_meta_r <= flash_data_in;
      din_sync_r <= din_meta_r;
    end
  end

  // caller supplies worst-case count
  // synchroniser adds latency, so the count must include two extra cycles margin
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_rdata <= '0;
    end else if (state_r == PFW_ACCESS && cnt_zero) begin
      rsp_rdata <= din_sync_r;
    end
  end

  // handshake outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      rsp_valid <= (state_r == PFW_HOLD || state_r == PFW_ACCESS) && cnt_zero;
      req_ready <= (state_r == PFW_DONE);
    end
  end

  // checker helper: cycles with a select low, so phase lengths are judged at the pins
  assign all_sel_n = flash_select_first_n & boot_flash_select_n & flash_select_third_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_lo_cnt_r <= '0;
    end else begin
      sel_lo_cnt_r <= all_sel_n ? '0 : sel_lo_cnt_r + 1'b1;
    end
  end

  sequence s_we_fall;
    $fell(flash_write_strobe_n);
  endsequence
  sequence s_we_rise;
    $rose(flash_write_strobe_n);
  endsequence
  property p_setup_len;
    @(posedge core_clk) disable iff (!arst_n)
      s_we_fall |-> sel_lo_cnt_r == ({1'b0, setup_r} + 6'h01);
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup phase wrong");

  property p_pulse_len;
    @(posedge core_clk) disable iff (!arst_n)
      s_we_rise |-> sel_lo_cnt_r == ({1'b0, setup_r} + {1'b0, pulse_r} + 6'h02);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("strobe pulse wrong");

  // strobe low never while select idle
  property p_strobe_sel;
    @(posedge core_clk) disable iff (!arst_n)
      !flash_write_strobe_n |-> (flash_select_first_n + boot_flash_select_n
        + flash_select_third_n) == 2'h2;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");

  property p_one_sel;
    @(posedge core_clk) disable iff (!arst_n)
      ({1'b0, flash_select_first_n} + {1'b0, boot_flash_select_n}
        + {1'b0, flash_select_third_n}) >= 2'h2;
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects active");

  property p_boot;
    @(posedge core_clk) disable iff (!arst_n)
      (start && req_sel == PFW_SEL_BOOT) |=> !boot_flash_select_n;
  endproperty
  a_boot: assert property (p_boot) else $error("boot select missing");

  // select still low on strobe rise
  property p_hold;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(flash_write_strobe_n) |-> !(flash_select_first_n && boot_flash_select_n
        && flash_select_third_n);
  endproperty
  a_hold: assert property (p_hold) else $error("select released early");

  property p_acc;
    @(posedge core_clk) disable iff (!arst_n)
      (start && !req_write) |-> ##[1:21] rsp_valid;
  endproperty
  a_acc: assert property (p_acc) else $error("read too long");

  property p_max;
    @(posedge core_clk) disable iff (!arst_n) cnt <= PFW_WS_MAX;
  endproperty
  a_max: assert property (p_max) else $error("count above ceiling");

  property p_wr;
    @(posedge core_clk) disable iff (!arst_n)
      (start && req_write) |-> ##[3:62] rsp_valid;
  endproperty
  a_wr: assert property (p_wr) else $error("write too long");

  // read data is the pin value three edges back
  property p_rd;
    @(posedge core_clk) disable iff (!arst_n)
      (state_r == PFW_ACCESS && cnt_zero) |=> rsp_rdata == $past(flash_data_in, 3);
  endproperty
  a_rd: assert property (p_rd) else $error("read data mismatch");
endmodule : pfw_sequencer

/* hdl/pfw_ws_counter.sv */
`timescale 1ns/1ps
// loadable down-counter; zero flags the end of a timed phase
module pfw_ws_counter
  import pfw_pkg::*;
#(
  parameter int WIDTH = PFW_WS_W
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic [WIDTH-1:0] count,
  output logic zero
);
  // count down one per clock, hold at zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign zero = (count == '0);

  // a counter narrower than the count ports would wrap a long phase
  if (WIDTH < PFW_WS_W) begin : g_width_chk
    $error("wait-state counter narrower than the count ports");
  end
endmodule : pfw_ws_counter

/* tb/pfw_flash_model.sv */
`timescale 1ns/1ps
// far-side flash: answers reads from the address, keeps the last write
module pfw_flash_model
  import pfw_pkg::*;
(
  input wire logic core_clk,
  input wire logic [2:0] sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe,
  input wire logic [PFW_ADDR_W-1:0] addr,
  input wire logic [PFW_DATA_W-1:0] wdata,
  output logic [PFW_DATA_W-1:0] rdata
);
  logic [PFW_DATA_W-1:0] last_q = 16'h0;
  logic [1:0] idx;
  logic [PFW_DATA_W-1:0] wr_word;
  logic [PFW_ADDR_W-1:0] wr_addr;
  logic wr_oe;
  // released bus toggles each cycle so a stale sample never matches
  assign idx = !sel_n[0] ? 2'h0 : (!sel_n[1] ? 2'h1 : 2'h2);
  assign rdata = (&sel_n || rd_n) ? ~last_q : addr[15:0] ^ {idx, 14'h0};
  always @(posedge core_clk) last_q <= rdata;
  // a write lands on the rising edge of the strobe
  always @(posedge wr_n) begin
    if (!(&sel_n)) begin
      wr_word <= wdata;
      wr_addr <= addr;
      wr_oe <= oe;
    end
  end
endmodule : pfw_flash_model

/* tb/pfw_sequencer_tb_top.sv */
`timescale 1ns/1ps
module pfw_sequencer_tb_top;
  import pfw_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_sel = 2'h0;
  logic [PFW_ADDR_W-1:0] req_addr = '0;
  logic [PFW_ADDR_W-1:0] f_addr;
  logic [PFW_DATA_W-1:0] req_wdata = '0, f_din, rsp_rdata, f_dout, got_rd;
  logic [PFW_WS_W-1:0] s_c = 5'h02, p_c = 5'h0b, h_c = 5'h02, a_c = 5'h13;
  logic req_ready, rsp_valid, fs0_n, fs1_n, fs2_n, we_n, rd_n, oe;
  int mismatches = 0, n_tests = 0, cyc = 0;
  int n_su, n_wp, n_ho, n_rd, n_oth, n_rsp;

  pfw_sequencer i_dut (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_sel(req_sel), .req_addr(req_addr), .req_wdata(req_wdata),
    .setup_count(s_c), .write_pulse_count(p_c), .select_hold_count(h_c),
    .read_access_count(a_c), .flash_data_in(f_din), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_select_first_n(fs0_n),
    .boot_flash_select_n(fs1_n), .flash_select_third_n(fs2_n),
    .flash_write_strobe_n(we_n), .flash_read_strobe_n(rd_n), .flash_addr(f_addr),
    .flash_data_out(f_dout), .flash_data_oe(oe));
  pfw_flash_model i_fm (.core_clk(core_clk), .sel_n({fs2_n, fs1_n, fs0_n}), .rd_n(rd_n),
    .wr_n(we_n), .oe(oe), .addr(f_addr), .wdata(f_dout), .rdata(f_din));

  initial forever #50 core_clk = ~core_clk;
  // hang guard; a full run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [4:0] cl(input logic [4:0] v);
    return (v > PFW_WS_MAX) ? PFW_WS_MAX : v;
  endfunction : cl

  // one transfer; tallies strobe phases on settled samples at the falling edge
  task automatic xfer(input logic wr, input logic [1:0] sel, input logic [4:0] s, p, h, a,
                      input logic [PFW_ADDR_W-1:0] ad, input logic [PFW_DATA_W-1:0] wd);
    logic [2:0] sn;
    logic seen_we;
    n_su = 0; n_wp = 0; n_ho = 0; n_rd = 0; n_oth = 0; n_rsp = 0;
    seen_we = 1'b0;
    @(posedge core_clk);
    req_valid <= 1'b1; req_write <= wr; req_sel <= sel; req_addr <= ad; req_wdata <= wd;
    s_c <= s; p_c <= p; h_c <= h; a_c <= a;
    repeat (80) begin
      @(negedge core_clk);
      sn = {fs2_n, fs1_n, fs0_n};
      if (sel < 2'h3 && !sn[sel]) begin
        if (!we_n) n_wp++;
        else if (seen_we) n_ho++;
        else n_su++;
      end
      if (!we_n) seen_we = 1'b1;
      if (!rd_n) n_rd++;
      n_oth += $countones(~sn);
      if (rsp_valid === 1'b1) begin
        n_rsp++;
        got_rd = rsp_rdata;
      end
      if (req_ready === 1'b1) break;
    end
    // request held until the edge that samples ready high
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : xfer

  task automatic t_reset();
    chk("selects idle", 3'h7, {fs2_n, fs1_n, fs0_n});
    chk("strobes idle", 2'h3, {we_n, rd_n});
    chk("oe idle", 1'b0, oe);
  endtask : t_reset

  // write phases follow the programmed counts, clipped at the maximum
  task automatic t_write(input logic [1:0] sel, input logic [4:0] s, p, h);
    logic [PFW_ADDR_W-1:0] ad;
    logic [PFW_DATA_W-1:0] wd;
    ad = {sel, 16'hc35a, s};
    wd = {s, p, h, 1'b1};
    xfer(1'b1, sel, s, p, h, 5'h00, ad, wd);
    chk("setup", cl(s) + 1, n_su);
    chk("pulse", cl(p) + 1, n_wp);
    chk("hold", cl(h) + 1, n_ho);
    chk("other select", n_su + n_wp + n_ho, n_oth);
    chk("read strobe", 0, n_rd);
    chk("done", 1, n_rsp);
    chk("write addr", ad, i_fm.wr_addr);
    chk("write data", wd, i_fm.wr_word);
    chk("write oe", 1'b1, i_fm.wr_oe);
  endtask : t_write

  // read samples the flash after the access count
  task automatic t_read(input logic [1:0] sel, input logic [4:0] a);
    logic [PFW_ADDR_W-1:0] ad;
    ad = {sel, 16'h3ca5, a};
    xfer(1'b0, sel, 5'h00, 5'h00, 5'h00, a, ad, 16'h0);
    chk("target select", (sel < 2'h3) ? cl(a) + 1 : 0, n_su);
    chk("any select", (sel < 2'h3) ? cl(a) + 1 : 0, n_oth);
    chk("done", 1, n_rsp);
    if (sel < 2'h3) begin
      chk("access", cl(a) + 1, n_rd);
      chk("read data", ad[15:0] ^ {sel, 14'h0}, got_rd);
    end
  endtask : t_read

  initial begin
    repeat (16) @(posedge core_clk);
    t_reset();
    arst_n <= 1'b1;
    t_write(PFW_SEL_FIRST, PFW_SETUP_DEF, PFW_PULSE_DEF, PFW_HOLD_DEF);
    t_write(PFW_SEL_BOOT, 5'h00, 5'h00, 5'h00);
    t_write(PFW_SEL_THIRD, 5'h13, 5'h1f, 5'h01);
    t_read(PFW_SEL_BOOT, PFW_ACC_DEF);
    t_read(PFW_SEL_FIRST, 5'h03);
    t_read(PFW_SEL_THIRD, 5'h1f);
    t_read(2'h3, 5'h04);
    close_out();
  end
endmodule : pfw_sequencer_tb_top
